// ---- design/spira_dev.sv ----
/*
  Device end: serial slave that reads and writes a byte-wide address space.
  Assumes the link clock (sclk) is the only clock at the pins; the memory side
  runs on sys_clk; memRdata must be valid one sys_clk after memRead rises.
*/
`timescale 1ns/1ps
// Contract
// - slave only, clock modes 0 and 3
// - sample on rising, shift on falling
// - frame is command, address, data: 32 bits
// - all fields shifted MSB first
// - 0xF0 writes byte, 0x0F reads byte
// - unknown command ignored, no state change
// - serial port active only with strap
// - select low starts a frame
// - select high ends frame, clears counter
// - no transfers before lock wait ends
module spira_dev
  import spira_pkg::*;
#(
  parameter int LOCK_CYCLES = SPIRA_LOCK_CYCLES
) (
  spira_if.dev link,
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic spiSelect,
  output logic memWrite,
  output logic memRead,
  output logic [15:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic [7:0] memRdata,
  output logic internal_pll_locked
);
  // ******************************
  // link domain (sclk)
  // ******************************
  logic [5:0] bitCnt_ff;
  logic [30:0] shift_ff;
  logic [7:0] txByte_ff;
  logic misoOut_ff;
  logic reqTgl_ff;
  logic isWrite_ff;
  logic [23:0] reqInfo_ff;
  logic [7:0] reqData_ff;
  logic [7:0] rdData_ff;
  logic isRead_ff;
  logic oeOn_ff;
  logic selSync1_ff;
  logic selSync2_ff;
  logic portOn;
  logic [7:0] cmdNow;

  // frame state is held in reset by the deselected select, so each frame starts clean
  assign portOn = selSync2_ff & internal_pll_locked;
  assign cmdNow = shift_ff[30:23];

  always_ff @(posedge link.sclk or posedge link.ssN) begin
    if (link.ssN) begin
      bitCnt_ff <= 6'h00;
      shift_ff <= 31'h0;
      isRead_ff <= 1'b0;
    end else begin
      shift_ff <= {shift_ff[29:0], link.mosi};
      // the shifter holds the command only at bit 32, so a read is latched early
      if (bitCnt_ff == 6'(SPIRA_DATA_BITS - 1)) begin
        isRead_ff <= ({shift_ff[6:0], link.mosi} == SPIRA_OP_READ);
      end
      if (bitCnt_ff != 6'h3F) begin
        bitCnt_ff <= bitCnt_ff + 6'h01;
      end
    end
  end

  // request leaves the link domain as a toggle; payload is written on the same sclk edge and is stable before the toggle is synchronised
  always_ff @(posedge link.sclk or posedge srst) begin
    if (srst) begin
      reqTgl_ff <= 1'b0;
      isWrite_ff <= 1'b0;
      reqInfo_ff <= 24'h0;
      reqData_ff <= 8'h00;
    end else if (!link.ssN && portOn) begin
      // read request goes out after the address: bit 24 sampled at count 23
      if (bitCnt_ff == 6'(SPIRA_FRAME_BITS - SPIRA_DATA_BITS - 1) && isRead_ff) begin
        reqTgl_ff <= ~reqTgl_ff;
        isWrite_ff <= 1'b0;
        reqInfo_ff <= {shift_ff[22:0], link.mosi};
      end else if (bitCnt_ff == 6'(SPIRA_FRAME_BITS - 1) && cmdNow == SPIRA_OP_WRITE) begin
        reqTgl_ff <= ~reqTgl_ff;
        isWrite_ff <= 1'b1;
        reqInfo_ff <= shift_ff[30:7];
        reqData_ff <= {shift_ff[6:0], link.mosi};
      end
      // any other command falls through: nothing is requested
    end
  end

  // read data crosses as a word that settles four sys_clk cycles after bit 24 is sampled;
  // limitation: half an sclk period must exceed that, no handshake fits inside it

  always_ff @(negedge link.sclk or posedge link.ssN) begin
    if (link.ssN) begin
      misoOut_ff <= 1'b0;
      txByte_ff <= 8'h00;
      oeOn_ff <= 1'b0;
    end else begin
      if (bitCnt_ff == 6'(SPIRA_FRAME_BITS - SPIRA_DATA_BITS)) begin
        misoOut_ff <= rdData_ff[7];
        oeOn_ff <= isRead_ff & portOn;
        txByte_ff <= {rdData_ff[6:0], 1'b0};
      end else begin
        misoOut_ff <= txByte_ff[7];
        txByte_ff <= {txByte_ff[6:0], 1'b0};
      end
    end
  end

  assign link.misoOut = misoOut_ff;
  assign link.misoOe = oeOn_ff & ~link.ssN;

  // ******************************
  // system domain (sys_clk)
  // ******************************
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic [22:0] lockCnt_ff;
  logic [22:0] nxt_lockCnt;
  logic locked_ff;
  logic nxt_locked;
  logic wr_ff;
  logic nxt_wr;
  logic rd_ff;
  logic nxt_rd;
  logic [15:0] addr_ff;
  logic [15:0] nxt_addr;
  logic [7:0] wdata_ff;
  logic [7:0] nxt_wdata;
  logic [7:0] nxt_rdData;
  logic rdPend_ff;
  logic nxt_rdPend;

  always_comb begin
    nxt_lockCnt = lockCnt_ff;
    nxt_locked = locked_ff;
    nxt_wr = 1'b0;
    nxt_rd = 1'b0;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdPend = 1'b0;
    nxt_rdData = rdData_ff;
    if (lockCnt_ff == 23'(LOCK_CYCLES - 1)) begin
      nxt_locked = 1'b1;
    end else begin
      nxt_lockCnt = lockCnt_ff + 23'h1;
    end
    if (s3_ff != s2_ff) begin
      nxt_addr = reqInfo_ff[15:0];
      nxt_wdata = reqData_ff;
      nxt_wr = isWrite_ff;
      nxt_rd = ~isWrite_ff;
      nxt_rdPend = ~isWrite_ff;
    end
    if (rdPend_ff) begin
      nxt_rdData = memRdata;
    end
  end

  // rdData_ff is written only here and read in the link domain on the sclk falling edge after bit 24 is sampled
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      lockCnt_ff <= 23'h0;
      locked_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      addr_ff <= 16'h0000;
      wdata_ff <= 8'h00;
      selSync1_ff <= 1'b0;
      selSync2_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      rdData_ff <= 8'h00;
    end else begin
      s1_ff <= reqTgl_ff;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lockCnt_ff <= nxt_lockCnt;
      locked_ff <= nxt_locked;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      selSync1_ff <= spiSelect;
      selSync2_ff <= selSync1_ff;
      rdPend_ff <= nxt_rdPend;
      rdData_ff <= nxt_rdData;
    end
  end

  assign memWrite = wr_ff;
  assign memRead = rd_ff;
  assign memAddr = addr_ff;
  assign memWdata = wdata_ff;
  assign internal_pll_locked = locked_ff;
endmodule

// ---- design/spira_if.sv ----
/*
  Four-wire link between the master end and the device end.
  Assumes the bench resolves nothing: miso follows misoOut only when misoOe is high and reads 1 otherwise.
*/
`timescale 1ns/1ps
interface spira_if;
  logic sclk;
  logic ssN;
  logic mosi;
  logic misoOut;
  logic misoOe;
  logic miso;
  assign miso = misoOe ? misoOut : 1'b1;
  modport dev (input sclk, input ssN, input mosi, output misoOut, output misoOe);
  modport mst (output sclk, output ssN, output mosi, input miso);
endinterface

// ---- design/spira_mst.sv ----
/*
  Master end: issues one 32-bit frame per request in mode 0.
  Assumes the device end samples on rising and shifts on falling sclk.
*/
`timescale 1ns/1ps
module spira_mst
  import spira_pkg::*;
(
  spira_if.mst link,
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [15:0] reqAddr,
  input wire logic [7:0] reqWdata,
  output logic reqReady,
  output logic rspValid,
  output logic [7:0] rspData
);
  // ******************************
  // frame sequencer
  // ******************************
  spira_mst_t st_ff, nxt_st;
  logic [31:0] tx_ff, nxt_tx;
  logic [7:0] rx_ff, nxt_rx;
  logic [5:0] bits_ff, nxt_bits;
  logic [2:0] div_ff, nxt_div;
  logic sclk_ff, nxt_sclk;
  logic ssN_ff, nxt_ssN;
  logic rdy_ff, nxt_rdy;
  logic vld_ff, nxt_vld;
  logic m1_ff, m2_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_bits = bits_ff;
    nxt_div = div_ff + 3'h1;
    nxt_sclk = sclk_ff;
    nxt_ssN = ssN_ff;
    nxt_rdy = rdy_ff;
    nxt_vld = 1'b0;
    case (st_ff)
      SPIRA_M_IDLE: begin
        nxt_div = 3'h0;
        nxt_rdy = 1'b1;
        if (reqValid && rdy_ff) begin
          nxt_tx = {reqWrite ? SPIRA_OP_WRITE : SPIRA_OP_READ, reqAddr, reqWdata};
          nxt_ssN = 1'b0;
          nxt_rdy = 1'b0;
          nxt_bits = 6'h00;
          nxt_st = SPIRA_M_LOW;
        end
      end
      SPIRA_M_LOW: begin
        if (div_ff == 3'(SPIRA_SCK_HALF - 1)) begin
          nxt_div = 3'h0;
          nxt_sclk = 1'b1;
          nxt_rx = {rx_ff[6:0], m2_ff};
          nxt_st = SPIRA_M_HIGH;
        end
      end
      SPIRA_M_HIGH: begin
        if (div_ff == 3'(SPIRA_SCK_HALF - 1)) begin
          nxt_div = 3'h0;
          nxt_sclk = 1'b0;
          nxt_tx = {tx_ff[30:0], 1'b0};
          nxt_bits = bits_ff + 6'h01;
          nxt_st = (bits_ff == 6'(SPIRA_FRAME_BITS - 1)) ? SPIRA_M_END : SPIRA_M_LOW;
        end
      end
      SPIRA_M_END: begin
        if (div_ff == 3'(SPIRA_SCK_HALF - 1)) begin
          nxt_ssN = 1'b1;
          nxt_st = SPIRA_M_DONE;
        end
      end
      SPIRA_M_DONE: begin
        nxt_vld = 1'b1;
        nxt_st = SPIRA_M_IDLE;
      end
      default: nxt_st = SPIRA_M_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff <= SPIRA_M_IDLE;
      tx_ff <= 32'h0;
      rx_ff <= 8'h00;
      bits_ff <= 6'h00;
      div_ff <= 3'h0;
      sclk_ff <= 1'b0;
      ssN_ff <= 1'b1;
      rdy_ff <= 1'b0;
      vld_ff <= 1'b0;
      m1_ff <= 1'b0;
      m2_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      bits_ff <= nxt_bits;
      div_ff <= nxt_div;
      sclk_ff <= nxt_sclk;
      ssN_ff <= nxt_ssN;
      rdy_ff <= nxt_rdy;
      vld_ff <= nxt_vld;
      m1_ff <= link.miso;
      m2_ff <= m1_ff;
    end
  end

  // miso goes through two flops, so the sample lags; half period is long enough
  assign link.sclk = sclk_ff;
  assign link.ssN = ssN_ff;
  assign link.mosi = tx_ff[31];
  assign reqReady = rdy_ff;
  assign rspValid = vld_ff;
  assign rspData = rx_ff;
endmodule

// ---- design/spira_pkg.sv ----
/*
  Constants shared by both ends of the serial register-access link.
  Assumes a 25 MHz system clock on each end.
*/
package spira_pkg;
  localparam logic [7:0] SPIRA_OP_WRITE = 8'hF0;
  localparam logic [7:0] SPIRA_OP_READ = 8'h0F;
  localparam int SPIRA_FRAME_BITS = 32;
  localparam int SPIRA_DATA_BITS = 8;
  localparam int SPIRA_CNT_W = 6;
  localparam int SPIRA_CLK_HZ = 25000000;
  localparam int SPIRA_LOCK_MS = 10;
  localparam int SPIRA_LOCK_CYCLES = SPIRA_LOCK_MS * (SPIRA_CLK_HZ / 1000);
  localparam int SPIRA_SCK_HALF = 6;
  typedef enum logic [2:0] {
    SPIRA_M_IDLE = 3'h0,
    SPIRA_M_LOW = 3'h1,
    SPIRA_M_HIGH = 3'h3,
    SPIRA_M_END = 3'h2,
    SPIRA_M_DONE = 3'h6
  } spira_mst_t;
endpackage

// ---- tb/spi_slave_register_access_test.sv ----
/* Self-checking bench: master end joined to device end, plus a bench-driven
   mode 3 link into a second device. Assumes a 25 MHz sys_clk. */
`timescale 1ns/1ps
module spi_slave_register_access_test
  import spira_pkg::*;
;
  localparam int LOCK = 1000;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic spiSelect = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [15:0] reqAddr = 16'h0000;
  logic [7:0] reqWdata = 8'h00;
  logic [7:0] memRdata;
  logic [7:0] rsp, wrD, wr2D;
  logic [15:0] wrA, rdA, wr2A;
  logic reqReady, rspValid, memWrite, memRead, locked, memWrite2;
  logic [7:0] rspData, memWdata, memWdata2;
  logic [15:0] memAddr, memAddr2;
  int errorCnt = 0;
  int checks = 0;
  int wrCnt = 0;
  int rdCnt = 0;
  int wr2Cnt = 0;
  logic [15:0] ta [3] = '{16'h0000, 16'hFFFF, 16'hA55A};
  logic [7:0] td [3] = '{8'h00, 8'hFF, 8'h3C};
  always #20 sys_clk = ~sys_clk;
  spira_if link();
  spira_if link2();
  spira_mst spira_mst_i (.link(link), .sys_clk(sys_clk), .srst(srst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));
  spira_dev #(.LOCK_CYCLES(LOCK)) spira_dev_i (.link(link), .sys_clk(sys_clk), .srst(srst), .spiSelect(spiSelect),
    .memWrite(memWrite), .memRead(memRead), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .internal_pll_locked(locked));
  spira_dev #(.LOCK_CYCLES(LOCK)) spira_dev_bb_i (.link(link2), .sys_clk(sys_clk), .srst(srst), .spiSelect(1'b1),
    .memWrite(memWrite2), .memRead(), .memAddr(memAddr2), .memWdata(memWdata2), .memRdata(8'h00),
    .internal_pll_locked());
  spira_link_monitor spira_link_monitor_i (.sys_clk(sys_clk), .srst(srst), .sclk(link.sclk), .ssN(link.ssN),
    .mosi(link.mosi), .misoOut(link.misoOut), .misoOe(link.misoOe), .miso(link.miso));
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h5A;
  endfunction
  // memory answers combinationally from the registered address, valid in the cycle memRead rises
  assign memRdata = pat(memAddr);
  always @(posedge sys_clk) begin
    if (memWrite) begin
      wrCnt <= wrCnt + 1;
      wrA <= memAddr;
      wrD <= memWdata;
    end
    if (memRead) begin
      rdCnt <= rdCnt + 1;
      rdA <= memAddr;
    end
    if (memWrite2) begin
      wr2Cnt <= wr2Cnt + 1;
      wr2A <= memAddr2;
      wr2D <= memWdata2;
    end
  end
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    if (reqReady !== 1'b1) errorCnt++;
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= a;
    reqWdata <= d;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 600) begin
      @(negedge sys_clk);
      n++;
    end
    if (rspValid !== 1'b1) errorCnt++;
    rsp = rspData;
    repeat (8) @(negedge sys_clk);
  endtask
  // mode 3: sclk rests high between frames, mosi shows the inverse once released
  task bb(input logic [31:0] f);
    link2.ssN = 1'b0;
    #24;
    for (int i = 31; i >= 0; i--) begin
      link2.sclk = 1'b0;
      link2.mosi = f[i];
      #24;
      link2.sclk = 1'b1;
      #24;
    end
    link2.ssN = 1'b1;
    link2.mosi = ~f[0];
    repeat (8) @(negedge sys_clk);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge sys_clk);
    errorCnt++;
    test_done;
  end
  initial begin
    link2.ssN = 1'b1;
    link2.sclk = 1'b1;
    link2.mosi = 1'b0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    spiSelect <= 1'b1;
    xfer(1'b0, 16'h1234, 8'h00);
    chk("early read", rsp, 8'hFF);
    chk("early lock", locked, 1'b0);
    chk("early reads", rdCnt, 0);
    repeat (LOCK) @(negedge sys_clk);
    chk("lock", locked, 1'b1);
    $display("test lock done");
    spiSelect <= 1'b0;
    xfer(1'b1, 16'h0001, 8'h11);
    chk("strap off writes", wrCnt, 0);
    spiSelect <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, ta[i], td[i]);
      chk("write count", wrCnt, i + 1);
      chk("write addr", wrA, ta[i]);
      chk("write data", wrD, td[i]);
    end
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, ta[i], 8'h00);
      chk("read data", rsp, pat(ta[i]));
      chk("read addr", rdA, ta[i]);
      chk("read count", rdCnt, i + 1);
    end
    $display("test master frames done");
    bb({8'hAA, 16'h1234, 8'h77});
    bb({8'h00, 16'h0000, 8'hFF});
    chk("unknown op writes", wr2Cnt, 0);
    bb({SPIRA_OP_WRITE, 16'hBEEF, 8'hC3});
    chk("mode 3 count", wr2Cnt, 1);
    chk("mode 3 addr", wr2A, 16'hBEEF);
    chk("mode 3 data", wr2D, 8'hC3);
    $display("test mode 3 done");
    test_done;
  end
endmodule

// ---- tb/spira_link_monitor.sv ----
/* Assertion checker for the serial link joining master and device ends.
   Assumes sclk is slow against sys_clk, six sys_clk cycles per level. */
`timescale 1ns/1ps
module spira_link_monitor
  import spira_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic ssN,
  input wire logic mosi,
  input wire logic misoOut,
  input wire logic misoOe,
  input wire logic miso
);
  logic sclkQ_ff, nxt_sclkQ;
  logic [5:0] bitCnt_ff, nxt_bitCnt;
  logic [7:0] cmd_ff, nxt_cmd;
  always_comb begin
    nxt_sclkQ = sclk;
    nxt_bitCnt = bitCnt_ff;
    nxt_cmd = cmd_ff;
    if (ssN) begin
      nxt_bitCnt = 6'h00;
    end else if (sclk && !sclkQ_ff) begin
      nxt_bitCnt = bitCnt_ff + 6'h01;
      if (bitCnt_ff < 6'h08) begin
        nxt_cmd = {cmd_ff[6:0], mosi};
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sclkQ_ff <= 1'b0;
      bitCnt_ff <= 6'h00;
      cmd_ff <= 8'h00;
    end else begin
      sclkQ_ff <= nxt_sclkQ;
      bitCnt_ff <= nxt_bitCnt;
      cmd_ff <= nxt_cmd;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_high_phase;
    sclk [*6] ##1 !sclk;
  endsequence
  property p_high_phase;
    $rose(sclk) |-> s_high_phase;
  endproperty
  property p_idle_low;
    ssN |-> !sclk;
  endproperty
  property p_start;
    $fell(ssN) |-> !sclk;
  endproperty
  property p_mosi_hold;
    sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  property p_frame_len;
    $rose(ssN) |-> bitCnt_ff == 6'h20;
  endproperty
  property p_miso_hiz;
    ssN && $past(ssN) |-> !misoOe;
  endproperty
  property p_read_only;
    misoOe |-> cmd_ff == SPIRA_OP_READ && bitCnt_ff >= 6'h18;
  endproperty
  property p_miso_hold;
    misoOe && sclk && $past(sclk) |-> $stable(miso);
  endproperty
  a_high_phase: assert property (p_high_phase) else $error("sclk high phase wrong");
  a_idle_low: assert property (p_idle_low) else $error("sclk not idle low");
  a_start: assert property (p_start) else $error("select fell with sclk high");
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while sclk high");
  a_frame_len: assert property (p_frame_len) else $error("frame not 32 bits");
  a_miso_hiz: assert property (p_miso_hiz) else $error("miso driven while deselected");
  a_read_only: assert property (p_read_only) else $error("miso driven outside read data");
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved while sclk high");
endmodule
